// >>> core/serial_status_pkg.sv
// Shared constants for the serial status flag block: register map,
// status and control bit positions, flag indices and reset values.
// Assumes a byte-wide register port with a three-bit word address.
package serial_status_pkg;

    // ****************************************************************
    // Register port geometry and offsets
    // ****************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_TXDATA = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_RXDATA = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h5;

    // ****************************************************************
    // Status byte layout
    // ****************************************************************
    localparam int POS_TX_HOLDING_EMPTY_FLAG = 7;
    localparam int POS_RX_HOLDING_FULL_FLAG = 6;
    localparam int POS_OVERRUN_ERROR_FLAG = 5;
    localparam int POS_ERR4 = 4;  // framing error, or error signal in smart-card layout
    localparam int POS_PER = 3;
    localparam int POS_TRANSMIT_END_FLAG = 2;
    localparam int POS_MPB = 1;
    localparam int POS_TRANSMIT_MULTIPROC_BIT = 0;

    // ****************************************************************
    // Control byte layout and reset values
    // ****************************************************************
    localparam int CTL_TE = 0;
    localparam int CTL_RE = 1;
    localparam int CTL_SMART = 2;
    localparam logic CTL_RESET = 1'h0;
    localparam logic TRANSMIT_END_FLAG_RESET = 1'h1;
    localparam logic MPB_RESET = 1'h0;
    localparam logic TRANSMIT_MULTIPROC_BIT_RESET = 1'h0;

    // ****************************************************************
    // Clear-only flag cells
    // ****************************************************************
    localparam int FLAG_N = 6;
    localparam int FL_TX_HOLDING_EMPTY_FLAG = 0;
    localparam int FL_RX_HOLDING_FULL_FLAG = 1;
    localparam int FL_OVERRUN_ERROR_FLAG = 2;
    localparam int FL_FER = 3;
    localparam int FL_PER = 4;
    localparam int FL_ERS = 5;
    localparam logic [FLAG_N-1:0] FLAG_RESET = 6'h01;

    // ****************************************************************
    // Interrupt status and mask layout
    // ****************************************************************
    localparam int IRQ_W = 4;
    localparam int IRQ_TXE = 0;
    localparam int IRQ_TRANSMIT_END_FLAG = 1;
    localparam int IRQ_RXF = 2;
    localparam int IRQ_ERR = 3;

endpackage : serial_status_pkg

// >>> core/serial_flag_cell.sv
// One clear-only status flag with its read-then-write-zero arming.
// Assumes reads and writes of the status byte never share a cycle.
`timescale 1ns/1ps

module serial_flag_cell #(
    parameter logic RESET_VALUE = 1'h0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Hardware events
    input wire logic i_set,
    input wire logic i_clr,
    // Software access to this bit
    input wire logic i_read,
    input wire logic i_write,
    input wire logic i_wbit,
    // Flag and accepted software clear
    output logic o_flag,
    output logic o_sw_clear
);

    typedef struct packed {
        logic flag;
        logic armed;
    } cell_t;

    cell_t st;
    cell_t next_st;

    // ****************************************************************
    // Flag update: set wins over every clear
    // ****************************************************************
    always_comb begin
        next_st = st;
        o_sw_clear = i_write && !i_wbit && st.armed;
        if (i_read && st.flag) begin
            next_st.armed = 1'h1;
        end
        // A one written only disarms; a zero only counts once armed
        if (i_write) begin
            next_st.armed = 1'h0;
            if (o_sw_clear) begin
                next_st.flag = 1'h0;
            end
        end
        if (i_clr) begin
            next_st.flag = 1'h0;
            next_st.armed = 1'h0;
        end
        if (i_set) begin
            next_st.flag = 1'h1;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '{flag: RESET_VALUE, armed: 1'h0};
        end else begin
            st <= next_st;
        end
    end

    assign o_flag = st.flag;

    // A write of one never clears a standing flag
    one_ignored_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_write && i_wbit && st.flag && !i_clr) |=> st.flag)
        else $error("flag cleared by a write of one");

endmodule : serial_flag_cell

// >>> core/serial_status_flags.sv
// Status flag logic of a serial port: transmit empty and end, receive
// full, overrun and error flags, multiprocessor bits, interrupt gating.
// Assumes the shift engines and transfer units run on i_clk and pulse
// their event inputs for one cycle each.
`timescale 1ns/1ps

// Behaviour
// - Transmit end flag reads only, resets to 1, set in standby, disabled or last bit with transmit empty set.
// - Transmit end clears on empty-flag software clear, transmit DMA start, transfer write.
// - Received multiprocessor bit captured per character, resets 0, held when receive off.
// - Writable transmit multiprocessor bit, reset 0, appended to every sent character.
// - Smart-card select picks smart-card layout; bit 7 is transmit empty, resets 1.
// - Transmit empty sets on reset, standby, transmit off, holding-to-shift move.
// - Transmit empty clears on software clear, transmit DMA start, transfer write.
// - Receive full is bit 6, resets 0, set only on error-free completed reception.
// - Receive full clears on standby, software clear, receive DMA start, transfer read.
// - Receive full keeps its value when receive enable is cleared.
// - Reception completing while receive full is set flags overrun, drops new byte.
// - Parity or framing error loads the byte, leaves full clear, blocks reception.
// - Overrun keeps old byte, blocks reception and synchronous transmission until cleared.
module serial_status_flags (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register port
    input wire logic [serial_status_pkg::ADDR_W-1:0] i_addr,
    input wire logic [serial_status_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [serial_status_pkg::DATA_W-1:0] o_rdata,
    // Power state
    input wire logic i_standby,
    // Transmit engine
    input wire logic i_tx_load,
    input wire logic i_tx_last_bit,
    input wire logic i_sync_mode,
    output logic [serial_status_pkg::DATA_W-1:0] o_tx_data,
    output logic o_tx_mpb,
    output logic o_tx_enable,
    output logic o_tx_blocked,
    // Receive engine
    input wire logic i_rx_done,
    input wire logic [serial_status_pkg::DATA_W-1:0] i_rx_data,
    input wire logic i_rx_mpb,
    input wire logic i_rx_parity_err,
    input wire logic i_rx_framing_err,
    input wire logic i_err_signal,
    output logic [serial_status_pkg::DATA_W-1:0] o_rx_data,
    output logic o_rx_enable,
    output logic o_rx_blocked,
    // Transfer units
    input wire logic i_dma_tx_start,
    input wire logic i_dma_rx_start,
    input wire logic i_xfer_tx_write,
    input wire logic [serial_status_pkg::DATA_W-1:0] i_xfer_tx_data,
    input wire logic i_xfer_rx_read,
    input wire logic i_xfer_keep_select,
    // Requests and interrupt
    output logic o_tx_empty_request,
    output logic o_rx_full_request,
    output logic o_irq
);
    import serial_status_pkg::*;

    typedef struct packed {
        logic te;
        logic re;
        logic smart;
        logic transmit_multiproc_bit;
        logic received_multiproc_bit;
        logic transmit_end_flag;
        logic [DATA_W-1:0] tx_data;
        logic [DATA_W-1:0] rx_data;
        logic [DATA_W-1:0] rdata;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic tx_req;
        logic rx_req;
        logic rx_blk;
        logic tx_blk;
    } state_t;

    state_t st;
    state_t next_st;
    logic [FLAG_N-1:0] flag;
    logic [FLAG_N-1:0] flag_set;
    logic [FLAG_N-1:0] flag_clr;
    logic [FLAG_N-1:0] flag_rd;
    logic [FLAG_N-1:0] flag_wr;
    logic [FLAG_N-1:0] flag_sw_clr;
    logic rd_status;
    logic wr_status;
    logic rx_blocked;
    logic rx_take;
    logic rx_err;
    logic rx_over;
    logic rx_bad;
    logic rx_good;
    logic tx_kill;
    logic rx_kill;
    logic tx_force;
    logic [IRQ_W-1:0] irq_ev;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Bit of the status byte that carries a given flag cell
    function automatic int flag_pos(input int idx);
        case (idx)
            FL_TX_HOLDING_EMPTY_FLAG: flag_pos = POS_TX_HOLDING_EMPTY_FLAG;
            FL_RX_HOLDING_FULL_FLAG: flag_pos = POS_RX_HOLDING_FULL_FLAG;
            FL_OVERRUN_ERROR_FLAG: flag_pos = POS_OVERRUN_ERROR_FLAG;
            FL_PER: flag_pos = POS_PER;
            default: flag_pos = POS_ERR4;
        endcase
    endfunction : flag_pos

    // Framing error and error signal share one bit; the layout decides
    function automatic logic flag_vis(input int idx, input logic smart);
        case (idx)
            FL_FER: flag_vis = !smart;
            FL_ERS: flag_vis = smart;
            default: flag_vis = 1'h1;
        endcase
    endfunction : flag_vis

    // Status byte as software sees it in the chosen layout
    function automatic logic [DATA_W-1:0] status_byte(input logic [FLAG_N-1:0] f,
                                                      input state_t s);
        status_byte = '0;
        status_byte[POS_TX_HOLDING_EMPTY_FLAG] = f[FL_TX_HOLDING_EMPTY_FLAG];
        status_byte[POS_RX_HOLDING_FULL_FLAG] = f[FL_RX_HOLDING_FULL_FLAG];
        status_byte[POS_OVERRUN_ERROR_FLAG] = f[FL_OVERRUN_ERROR_FLAG];
        status_byte[POS_ERR4] = s.smart ? f[FL_ERS] : f[FL_FER];
        status_byte[POS_PER] = f[FL_PER];
        status_byte[POS_TRANSMIT_END_FLAG] = s.transmit_end_flag;
        status_byte[POS_MPB] = s.received_multiproc_bit;
        status_byte[POS_TRANSMIT_MULTIPROC_BIT] = s.transmit_multiproc_bit;
    endfunction : status_byte

    // ****************************************************************
    // Event decode
    // ****************************************************************

    // Bus strobes on the status byte
    assign rd_status = i_rd && (i_addr == ADDR_STATUS);
    assign wr_status = i_wr && (i_addr == ADDR_STATUS);

    // Overrun, framing or parity error stalls reception until software or standby clears it
    assign rx_blocked = flag[FL_OVERRUN_ERROR_FLAG] || flag[FL_FER] || flag[FL_PER];
    assign rx_take = i_rx_done && st.re && !rx_blocked && !i_standby;
    assign rx_err = i_rx_parity_err || i_rx_framing_err;
    assign rx_over = rx_take && flag[FL_RX_HOLDING_FULL_FLAG];
    assign rx_bad = rx_take && !flag[FL_RX_HOLDING_FULL_FLAG] && rx_err;
    assign rx_good = rx_take && !flag[FL_RX_HOLDING_FULL_FLAG] && !rx_err;

    // Transfer writes and reads clear flags only when told not to keep them; DMA starts always clear
    assign tx_kill = i_dma_tx_start || (i_xfer_tx_write && !i_xfer_keep_select);
    assign rx_kill = i_dma_rx_start || (i_xfer_rx_read && !i_xfer_keep_select);
    assign tx_force = i_standby || !st.te;

    // Per-flag set and clear terms
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[FL_TX_HOLDING_EMPTY_FLAG] = tx_force || i_tx_load;
        flag_clr[FL_TX_HOLDING_EMPTY_FLAG] = tx_kill;
        flag_set[FL_RX_HOLDING_FULL_FLAG] = rx_good;
        flag_clr[FL_RX_HOLDING_FULL_FLAG] = i_standby || rx_kill;
        flag_set[FL_OVERRUN_ERROR_FLAG] = rx_over;
        flag_clr[FL_OVERRUN_ERROR_FLAG] = i_standby;
        flag_set[FL_FER] = rx_bad && i_rx_framing_err;
        flag_clr[FL_FER] = i_standby;
        flag_set[FL_PER] = rx_bad && i_rx_parity_err;
        flag_clr[FL_PER] = i_standby;
        flag_set[FL_ERS] = i_err_signal && st.te && st.smart && !i_standby;
        flag_clr[FL_ERS] = i_standby;
    end

    // ****************************************************************
    // Clear-only flag cells
    // ****************************************************************
    for (genvar g = 0; g < FLAG_N; g++) begin : g_flag
        assign flag_rd[g] = rd_status && flag_vis(g, st.smart);
        assign flag_wr[g] = wr_status && flag_vis(g, st.smart);
        serial_flag_cell #(
            .RESET_VALUE(FLAG_RESET[g])
        ) u_cell (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_set(flag_set[g]),
            .i_clr(flag_clr[g]),
            .i_read(flag_rd[g]),
            .i_write(flag_wr[g]),
            .i_wbit(i_wdata[flag_pos(g)]),
            .o_flag(flag[g]),
            .o_sw_clear(flag_sw_clr[g])
        );
    end

    // Interrupt events, one per source group
    always_comb begin
        irq_ev = '0;
        irq_ev[IRQ_TXE] = i_tx_load && st.te;
        irq_ev[IRQ_TRANSMIT_END_FLAG] = i_tx_last_bit && flag[FL_TX_HOLDING_EMPTY_FLAG] && st.te;
        irq_ev[IRQ_RXF] = rx_good;
        irq_ev[IRQ_ERR] = rx_over || rx_bad || flag_set[FL_ERS];
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_st = st;
        // Control and data writes
        if (i_wr) begin
            case (i_addr)
                ADDR_CONTROL: begin
                    next_st.te = i_wdata[CTL_TE];
                    next_st.re = i_wdata[CTL_RE];
                    next_st.smart = i_wdata[CTL_SMART];
                end
                ADDR_STATUS: next_st.transmit_multiproc_bit = i_wdata[POS_TRANSMIT_MULTIPROC_BIT];
                ADDR_TXDATA: next_st.tx_data = i_wdata;
                ADDR_IRQ_MASK: next_st.irq_mask = i_wdata[IRQ_W-1:0];
                default: next_st.transmit_multiproc_bit = st.transmit_multiproc_bit;
            endcase
        end
        // Transfer unit data beats the bus in the same cycle
        if (i_xfer_tx_write) begin
            next_st.tx_data = i_xfer_tx_data;
        end
        // Overrun leaves the older byte in place
        if (rx_good || rx_bad) begin
            next_st.rx_data = i_rx_data;
            next_st.received_multiproc_bit = i_rx_mpb;
        end
        // Transmit end: set terms win over clear terms
        if (flag_sw_clr[FL_TX_HOLDING_EMPTY_FLAG] || tx_kill) begin
            next_st.transmit_end_flag = 1'h0;
        end
        if (tx_force || (i_tx_last_bit && flag[FL_TX_HOLDING_EMPTY_FLAG])) begin
            next_st.transmit_end_flag = 1'h1;
        end
        // Sticky interrupt status, write one to clear, events win
        if (i_wr && (i_addr == ADDR_IRQ_STATUS)) begin
            next_st.irq_stat = st.irq_stat & ~i_wdata[IRQ_W-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | irq_ev;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
        // Requests and stall levels to the engines
        next_st.tx_req = st.te && flag[FL_TX_HOLDING_EMPTY_FLAG];
        next_st.rx_req = flag[FL_RX_HOLDING_FULL_FLAG];
        next_st.rx_blk = rx_blocked;
        next_st.tx_blk = i_sync_mode && rx_blocked;
        // Read data stands only in the cycle after the strobe
        next_st.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                ADDR_STATUS: next_st.rdata = status_byte(flag, st);
                ADDR_CONTROL: next_st.rdata = DATA_W'({st.smart, st.re, st.te});
                ADDR_TXDATA: next_st.rdata = st.tx_data;
                ADDR_RXDATA: next_st.rdata = st.rx_data;
                ADDR_IRQ_STATUS: next_st.rdata = DATA_W'(st.irq_stat);
                ADDR_IRQ_MASK: next_st.rdata = DATA_W'(st.irq_mask);
                default: next_st.rdata = '0;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
            st.te <= CTL_RESET;
            st.re <= CTL_RESET;
            st.smart <= CTL_RESET;
            st.transmit_end_flag <= TRANSMIT_END_FLAG_RESET;
            st.received_multiproc_bit <= MPB_RESET;
            st.transmit_multiproc_bit <= TRANSMIT_MULTIPROC_BIT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign o_rdata = st.rdata;
    assign o_tx_data = st.tx_data;
    assign o_tx_mpb = st.transmit_multiproc_bit;
    assign o_tx_enable = st.te;
    assign o_tx_blocked = st.tx_blk;
    assign o_rx_data = st.rx_data;
    assign o_rx_enable = st.re;
    assign o_rx_blocked = st.rx_blk;
    assign o_tx_empty_request = st.tx_req;
    assign o_rx_full_request = st.rx_req;
    assign o_irq = st.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    transmit_end_flag_forced_a: assert property (!st.te |=> st.transmit_end_flag)
        else $error("transmit end low while transmit disabled");
    transmit_end_flag_cleared_a: assert property ((st.te && i_dma_tx_start && !i_tx_last_bit
        && !i_standby) |=> !st.transmit_end_flag)
        else $error("transmit end kept after transmit DMA start");
    mpb_kept_a: assert property (!st.re |=> $stable(st.received_multiproc_bit))
        else $error("received multiprocessor bit moved while receive off");
    transmit_multiproc_bit_written_a: assert property (wr_status |=> o_tx_mpb == $past(i_wdata[POS_TRANSMIT_MULTIPROC_BIT]))
        else $error("transmit multiprocessor bit not written");
    smart_layout_a: assert property ((rd_status && st.smart)
        |=> o_rdata[POS_TX_HOLDING_EMPTY_FLAG] == $past(flag[FL_TX_HOLDING_EMPTY_FLAG])
            && o_rdata[POS_ERR4] == $past(flag[FL_ERS]))
        else $error("smart-card status layout wrong");
    tx_holding_empty_flag_loaded_a: assert property (i_tx_load |=> flag[FL_TX_HOLDING_EMPTY_FLAG])
        else $error("transmit empty not set on load");
    tx_holding_empty_flag_cleared_a: assert property ((st.te && i_dma_tx_start && !i_tx_load
        && !i_standby) |=> !flag[FL_TX_HOLDING_EMPTY_FLAG])
        else $error("transmit empty kept after transmit DMA start");
    rx_holding_full_flag_set_a: assert property (rx_good |=> flag[FL_RX_HOLDING_FULL_FLAG] ##1 o_rx_full_request)
        else $error("receive full not set after good reception");
    rx_holding_full_flag_standby_a: assert property (i_standby |=> !flag[FL_RX_HOLDING_FULL_FLAG])
        else $error("receive full survived standby");
    rx_holding_full_flag_kept_a: assert property ((!st.re && !i_standby && !rx_kill && !wr_status)
        |=> $stable(flag[FL_RX_HOLDING_FULL_FLAG]))
        else $error("receive full moved while receive off");
    overrun_drop_a: assert property (rx_over
        |=> flag[FL_OVERRUN_ERROR_FLAG] && $stable(o_rx_data) ##1 o_rx_blocked)
        else $error("overrun not flagged or byte overwritten");
    error_load_a: assert property (rx_bad
        |=> !flag[FL_RX_HOLDING_FULL_FLAG] && o_rx_data == $past(i_rx_data) ##1 o_rx_blocked)
        else $error("error reception handled wrongly");
    blocked_rx_a: assert property ((rx_blocked && i_rx_done)
        |=> $stable(o_rx_data) && !$rose(flag[FL_RX_HOLDING_FULL_FLAG]))
        else $error("reception taken while blocked");

endmodule : serial_status_flags

// >>> verif/serial_station_model.sv
// Remote serial station: hands over one received character per request.
// Assumes requests are spaced beyond its longest reply delay.
`timescale 1ns/1ps
module serial_station_model (
    // Clock and request
    input wire logic i_clk,
    input wire logic i_send,
    input wire logic [7:0] i_byte,
    input wire logic i_mpb,
    input wire logic i_perr,
    input wire logic [3:0] i_delay,
    // Completed character
    output logic o_done,
    output logic [7:0] o_data,
    output logic o_mpb,
    output logic o_perr
);
    logic [3:0] cnt;
    // ****************************************************************
    // Reply timing
    // ****************************************************************
    initial begin
        cnt = 4'h0;
        o_done = 1'b0;
        o_data = 8'hA5;
        o_mpb = 1'b0;
        o_perr = 1'b0;
    end
    // Data and multiprocessor bit scrambled, parity error held low outside the done cycle, so stale data never passes
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        o_data <= ~o_data;
        o_mpb <= ~o_mpb;
        o_perr <= 1'b0;
        if (i_send) cnt <= i_delay;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
            o_done <= 1'b1;
            o_data <= i_byte;
            o_mpb <= i_mpb;
            o_perr <= i_perr;
        end
    end
endmodule : serial_station_model

// >>> verif/tb_top.sv
// Self-checking bench for the serial status flags.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
module tb_top;
    import serial_status_pkg::*;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_standby = 1'b0;
    logic i_sync_mode = 1'b0, i_xfer_keep_select = 1'b0, snd = 1'b0, sm = 1'b0, sp = 1'b0;
    logic rd_d = 1'b0, rx_done, rx_mpb, rx_perr, o_tx_mpb, o_irq, o_rx_blocked, o_tx_blocked;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00, i_xfer_tx_data = 8'h00, sb = 8'h00, b1, b3, o_rdata;
    logic [7:0] rx_data, o_tx_data, o_rx_data;
    logic o_tx_enable, o_rx_enable, o_tx_empty_request, o_rx_full_request;
    logic [5:0] evs = 6'h00;
    logic [3:0] dly = 4'h1;
    logic [7:0] exp_q[$];
    int miscompares = 0, compares = 0, cyc = 0;
    // ****************************************************************
    // Clock, design and remote station
    // ****************************************************************
    always #5 i_clk = ~i_clk;
    serial_status_flags u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_standby(i_standby), .i_tx_load(evs[0]), .i_tx_last_bit(evs[1]),
        .i_sync_mode(i_sync_mode), .o_tx_data(o_tx_data), .o_tx_mpb(o_tx_mpb),
        .o_tx_enable(o_tx_enable), .o_tx_blocked(o_tx_blocked), .i_rx_done(rx_done),
        .i_rx_data(rx_data), .i_rx_mpb(rx_mpb), .i_rx_parity_err(rx_perr),
        .i_rx_framing_err(1'b0), .i_err_signal(1'b0), .o_rx_data(o_rx_data),
        .o_rx_enable(o_rx_enable), .o_rx_blocked(o_rx_blocked), .i_dma_tx_start(evs[2]),
        .i_dma_rx_start(evs[4]), .i_xfer_tx_write(evs[3]), .i_xfer_tx_data(i_xfer_tx_data),
        .i_xfer_rx_read(evs[5]), .i_xfer_keep_select(i_xfer_keep_select),
        .o_tx_empty_request(o_tx_empty_request), .o_rx_full_request(o_rx_full_request),
        .o_irq(o_irq));
    serial_station_model u_station (.i_clk(i_clk), .i_send(snd), .i_byte(sb), .i_mpb(sm),
        .i_perr(sp), .i_delay(dly), .o_done(rx_done), .o_data(rx_data), .o_mpb(rx_mpb),
        .o_perr(rx_perr));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic finish_test();
        if (miscompares == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk) i_wr <= 1'b0;
    endtask : wr
    // Read with its expected byte noted for the monitor
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk) i_rd <= 1'b0;
    endtask : rd
    task automatic ev(input int k);
        @(posedge i_clk) evs <= 6'(1 << k);
        @(posedge i_clk) evs <= 6'h00;
    endtask : ev
    // Fixed wait covers the station's longest delay of 8
    task automatic rx(input logic [7:0] b, input logic m, input logic p);
        @(posedge i_clk) {snd, sb, sm, sp, dly} <= {1'b1, b, m, p, 4'($urandom_range(1, 8))};
        @(posedge i_clk) snd <= 1'b0;
        repeat (12) @(posedge i_clk);
    endtask : rx
    // Read data stand only in the cycle after the strobe
    always @(posedge i_clk) rd_d <= i_rd;
    always @(negedge i_clk) if (rd_d && exp_q.size() != 0) chk("rdata", o_rdata, exp_q.pop_front());
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(89));
        b1 = 8'($urandom());
        b3 = 8'($urandom());
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(ADDR_STATUS, 8'h84);
        rd(3'h6, 8'h00);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, 8'h85);
        @(negedge i_clk) chk("tx_mpb", o_tx_mpb, 8'h01);
        wr(ADDR_CONTROL, 8'h03);
        wr(ADDR_IRQ_MASK, 8'h04);
        rd(ADDR_STATUS, 8'h85);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, 8'h01);
        ev(0);
        rd(ADDR_STATUS, 8'h81);
        @(negedge i_clk) chk("tx_req", o_tx_empty_request, 8'h01);
        ev(1);
        rd(ADDR_STATUS, 8'h85);
        ev(2);
        rd(ADDR_STATUS, 8'h01);
        @(negedge i_clk) chk("tx_req", o_tx_empty_request, 8'h00);
        ev(0);
        i_xfer_keep_select <= 1'b1;
        i_xfer_tx_data <= b3;
        ev(3);
        rd(ADDR_STATUS, 8'h81);
        i_xfer_keep_select <= 1'b0;
        ev(3);
        rd(ADDR_STATUS, 8'h01);
        @(negedge i_clk) chk("tx_data", o_tx_data, b3);
        rx(b1, 1'b1, 1'b0);
        rd(ADDR_STATUS, 8'h43);
        rd(ADDR_RXDATA, b1);
        @(negedge i_clk) chk("rx_req", o_rx_full_request, 8'h01);
        chk("rx_data", o_rx_data, b1);
        wr(ADDR_CONTROL, 8'h01);
        rd(ADDR_STATUS, 8'h43);
        @(negedge i_clk) chk("enables", {o_rx_enable, o_tx_enable}, 8'h01);
        chk("rx_req", o_rx_full_request, 8'h01);
        wr(ADDR_CONTROL, 8'h03);
        i_sync_mode <= 1'b1;
        rx(~b1, 1'b0, 1'b0);
        rd(ADDR_STATUS, 8'h63);
        rd(ADDR_RXDATA, b1);
        @(negedge i_clk) chk("rx_blocked", o_rx_blocked, 8'h01);
        chk("tx_blocked", o_tx_blocked, 8'h01);
        @(posedge i_clk) i_sync_mode <= 1'b0;
        rx(~b1, 1'b0, 1'b0);
        wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_STATUS, 8'h63);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, 8'h03);
        @(negedge i_clk) chk("rx_blocked", o_rx_blocked, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h00);
        @(negedge i_clk) chk("irq", o_irq, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h04);
        @(negedge i_clk) chk("irq", o_irq, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h0F);
        wr(ADDR_IRQ_STATUS, 8'h0F);
        @(negedge i_clk) chk("irq", o_irq, 8'h00);
        rx(b3, 1'b0, 1'b1);
        rd(ADDR_STATUS, 8'h09);
        rd(ADDR_RXDATA, b3);
        wr(ADDR_STATUS, 8'h01);
        for (int k = 4; k < 7; k++) begin
            rx(b1, 1'b0, 1'b0);
            rd(ADDR_STATUS, 8'h41);
            if (k < 6) ev(k);
            else i_standby <= 1'b1;
            rd(ADDR_STATUS, k < 6 ? 8'h01 : 8'h85);
            @(negedge i_clk) chk("rx_req", o_rx_full_request, 8'h00);
        end
        @(posedge i_clk) i_standby <= 1'b0;
        wr(ADDR_CONTROL, 8'h07);
        rd(ADDR_STATUS, 8'h85);
        repeat (3) @(posedge i_clk);
        finish_test();
    end
endmodule : tb_top
